//--- instr_timing_pkg.sv
// shared constants and types for the instruction timing sequencer
package instr_timing_pkg;

	// ----------------------------------------------------------------
	// timing figures
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 25;
	localparam logic [3:0] MAX_CLOCKS = 4'h8;
	localparam logic [3:0] COUNT_ONE = 4'h1;
	localparam logic [1:0] BYTES_ONE = 2'h1;

	// ----------------------------------------------------------------
	// opcodes with side effects outside the core
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_XWRITE_DP = 8'hF0;
	localparam logic [7:0] OP_XWRITE_R0 = 8'hF2;
	localparam logic [7:0] OP_XWRITE_R1 = 8'hF3;
	localparam logic [7:0] OP_CODE_READ_PC = 8'h83;
	localparam logic [7:0] OP_CODE_READ_DP = 8'h93;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] PC_RESET = 16'h0000;

	// decoded cost and class of one opcode
	typedef struct packed {
		logic [1:0] len;
		logic [3:0] clocks;
		logic cond;
		logic relJump;
		logic extWrite;
		logic codeRead;
	} instrInfo_t;

	// sequencer states, gray coded along opcode -> operand -> execute
	typedef enum logic [1:0] {
		ST_OPCODE = 2'b00,
		ST_OPERAND = 2'b01,
		ST_EXEC = 2'b11
	} seqState_t;

endpackage

//--- decode_if.sv
// opcode and decoded information between sequencer and decoder
interface decode_if;
	import instr_timing_pkg::*;
	logic [7:0] opcode;
	instrInfo_t info;
	modport seq (output opcode, input info);
	modport dec (input opcode, output info);
endinterface

//--- instr_decode.sv
// opcode decoder: byte count, clock cost and class of every opcode
module instr_decode
	import instr_timing_pkg::*;
(
	// opcode in, decoded info out
	decode_if.dec dif
);

	// ----------------------------------------------------------------
	// table helpers
	// ----------------------------------------------------------------
	function automatic instrInfo_t mk(input logic [1:0] l, input logic [3:0] c,
		input logic cd, input logic rj);
		instrInfo_t r;
		r = '0;
		r.len = l;
		r.clocks = c;
		r.cond = cd;
		r.relJump = rj;
		return r;
	endfunction

	// full map, same encodings as the reference set; only clocks differ
	// (RQ1) reference opcode map
	function automatic instrInfo_t decode(input logic [7:0] op);
		instrInfo_t r;
		logic [3:0] hi;
		hi = op[7:4];
		r = mk(2'h1, 4'h1, 1'b0, 1'b0);
		if (op[3]) begin
			// (RQ6) bank register forms
			case (hi)
				4'h7, 4'h8, 4'hA: r = mk(2'h2, 4'h2, 1'b0, 1'b0);
				4'hB: r = mk(2'h3, 4'h3, 1'b1, 1'b0);
				4'hD: r = mk(2'h2, 4'h2, 1'b1, 1'b0);
				default: r = mk(2'h1, 4'h1, 1'b0, 1'b0);
			endcase
		end else begin
			case (op[2:0])
				3'h6, 3'h7: begin
					// (RQ7) pointer indirect forms, incl (RQ12) and (RQ17)
					case (hi)
						4'h7, 4'h8, 4'hA: r = mk(2'h2, 4'h2, 1'b0, 1'b0);
						4'hB: r = mk(2'h3, 4'h4, 1'b1, 1'b0);
						default: r = mk(2'h1, 4'h2, 1'b0, 1'b0);
					endcase
				end
				3'h5: begin
					// (RQ8) direct operand; (RQ11) direct to direct
					case (hi)
						4'h7, 4'h8: r = mk(2'h3, 4'h3, 1'b0, 1'b0);
						4'hA: r = mk(2'h1, 4'h1, 1'b0, 1'b0);
						4'hB, 4'hD: r = mk(2'h3, 4'h3, 1'b1, 1'b0);
						default: r = mk(2'h2, 4'h2, 1'b0, 1'b0);
					endcase
				end
				3'h4: begin
					// (RQ10) accumulator unary ops in one clock
					case (hi)
						4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9: r = mk(2'h2, 4'h2, 1'b0, 1'b0);
						4'h8: r = mk(2'h1, 4'h8, 1'b0, 1'b0);
						4'hA: r = mk(2'h1, 4'h4, 1'b0, 1'b0);
						4'hB: r = mk(2'h3, 4'h3, 1'b1, 1'b0);
						default: r = mk(2'h1, 4'h1, 1'b0, 1'b0);
					endcase
				end
				3'h3: begin
					// (RQ9) immediate into direct; (RQ14) code reads
					case (hi)
						4'h4, 4'h5, 4'h6: r = mk(2'h3, 4'h3, 1'b0, 1'b0);
						4'h7, 4'h8, 4'h9, 4'hE, 4'hF: r = mk(2'h1, 4'h3, 1'b0, 1'b0);
						default: r = mk(2'h1, 4'h1, 1'b0, 1'b0);
					endcase
				end
				3'h2: begin
					// (RQ20) accumulator into direct, xor too
					case (hi)
						4'h0, 4'h1: r = mk(2'h3, 4'h4, 1'b0, 1'b0);
						4'h2, 4'h3: r = mk(2'h1, 4'h5, 1'b0, 1'b0);
						4'hE, 4'hF: r = mk(2'h1, 4'h3, 1'b0, 1'b0);
						default: r = mk(2'h2, 4'h2, 1'b0, 1'b0);
					endcase
				end
				3'h1: r = mk(2'h2, 4'h3, 1'b0, 1'b0);
				default: begin
					// (RQ13) data pointer load; (RQ16) stack; (RQ15) external
					case (hi)
						4'h0: r = mk(2'h1, 4'h1, 1'b0, 1'b0);
						4'h1, 4'h2, 4'h3: r = mk(2'h3, 4'h3, 1'b1, 1'b0);
						4'h4, 4'h5, 4'h6, 4'h7: r = mk(2'h2, 4'h2, 1'b1, 1'b0);
						4'h8: r = mk(2'h2, 4'h3, 1'b0, 1'b1);
						4'h9: r = mk(2'h3, 4'h3, 1'b0, 1'b0);
						4'hE, 4'hF: r = mk(2'h1, 4'h3, 1'b0, 1'b0);
						default: r = mk(2'h2, 4'h2, 1'b0, 1'b0);
					endcase
				end
			endcase
		end
		// (RQ5) external write class
		r.extWrite = (op == OP_XWRITE_DP) || (op == OP_XWRITE_R0) || (op == OP_XWRITE_R1);
		r.codeRead = (op == OP_CODE_READ_PC) || (op == OP_CODE_READ_DP);
		return r;
	endfunction

	// purely combinational so the sequencer decides in the opcode cycle
	assign dif.info = decode(dif.opcode);

endmodule

//--- instr_timing.sv
// instruction fetch and timing sequencer of the pipelined core
//
// Overview of operation
// (RQ1) opcodes, modes, flags match reference set
// (RQ2) all timing counted in system clocks
// (RQ3) most instructions: one clock per byte
// (RQ4) untaken conditional branch one clock shorter
// (RQ5) external write targets RAM or flash
// (RQ6) accumulator/bank register ops: 1 byte, 1 clock
// (RQ7) pointer indirect operand ops: 1 byte, 2 clocks
// (RQ8) direct or immediate operand: 2 bytes, 2 clocks
// (RQ9) logic immediate into direct: 3 bytes, 3 clocks
// (RQ10) accumulator clear, complement, rotate, swap: 1 clock
// (RQ11) direct/immediate into direct: 3 bytes, 3 clocks
// (RQ12) store into pointer indirect: 2 bytes, 2 clocks
// (RQ13) data pointer immediate load: 3 bytes, 3 clocks
// (RQ14) code byte read: 1 byte, 3 clocks
// (RQ15) external data read/write: 1 byte, 3 clocks
// (RQ16) push/pop direct: 2 bytes, 2 clocks
// (RQ17) low nibble exchange: 1 byte, 2 clocks
// (RQ18) no instruction exceeds eight clocks
// (RQ19) relative offset signed, from next instruction
// (RQ20) xor accumulator into direct: 2 bytes, 2 clocks
module instr_timing
	import instr_timing_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// program memory fetch
	input wire logic [7:0] codeByte,
	input wire logic codeValid,
	output logic [15:0] fetchAddr,
	// execution pipeline
	input wire logic branchCond,
	input wire logic pcLoad,
	input wire logic [15:0] pcLoadValue,
	input wire logic [7:0] accValue,
	input wire logic [15:0] dataPointer,
	input wire logic [7:0] pointerReg,
	input wire logic programStoreEnable,
	output logic [7:0] opcodeOut,
	output logic [7:0] operand1,
	output logic [7:0] operand2,
	output logic instrDone,
	output logic busy,
	// data memories
	output logic extWriteStrobe,
	output logic flashTarget,
	output logic [15:0] extAddr,
	output logic codeReadStrobe,
	output logic [15:0] codeReadAddr
);

	// ----------------------------------------------------------------
	// decoder
	// ----------------------------------------------------------------
	decode_if dif();
	instrInfo_t info;
	instrInfo_t infoReg;

	instr_decode u_dec (
		.dif(dif.dec)
	);

	// the decoder sees the live byte every cycle; its result is used only in the opcode cycle
	assign dif.opcode = codeByte;
	assign info = dif.info;

	// ----------------------------------------------------------------
	// sequencer state
	// ----------------------------------------------------------------
	seqState_t state_reg, state_next;
	logic [3:0] cnt_reg, cnt_next;
	logic [3:0] total_reg, total_next;
	logic [1:0] bytes_reg;
	logic taken_reg, taken_next;
	logic accept, operandTake, lastCycle;

	// sign extension of a relative offset
	function automatic logic [15:0] sext(input logic [7:0] rel);
		return {{8{rel[7]}}, rel};
	endfunction

	assign accept = (state_reg == ST_OPCODE) && codeValid;
	assign operandTake = (state_reg == ST_OPERAND) && codeValid;

	// next count, total and branch decision for this cycle
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		total_next = total_reg;
		taken_next = taken_reg;
		lastCycle = 1'b0;
		case (state_reg)
			ST_OPCODE: begin
				if (codeValid) begin
					// (RQ2) count starts at one on the opcode clock
					cnt_next = COUNT_ONE;
					total_next = info.clocks;
					taken_next = 1'b0;
					if (info.clocks == COUNT_ONE) begin
						lastCycle = 1'b1;
					end else if (info.len != BYTES_ONE) begin
						state_next = ST_OPERAND;
					end else begin
						state_next = ST_EXEC;
					end
				end
			end
			ST_OPERAND: begin
				if (codeValid) begin
					// (RQ3) one program byte taken per clock
					cnt_next = cnt_reg + COUNT_ONE;
					if ((bytes_reg + BYTES_ONE) == infoReg.len) begin
						// (RQ4) taken conditional branch costs one extra clock
						taken_next = infoReg.relJump || (infoReg.cond && branchCond);
						total_next = infoReg.clocks + {3'h0, infoReg.cond && branchCond};
						if (cnt_next == total_next) begin
							lastCycle = 1'b1;
							state_next = ST_OPCODE;
						end else begin
							state_next = ST_EXEC;
						end
					end
				end
			end
			ST_EXEC: begin
				cnt_next = cnt_reg + COUNT_ONE;
				if (cnt_next == total_reg) begin
					lastCycle = 1'b1;
					state_next = ST_OPCODE;
				end
			end
			default: begin
				state_next = ST_OPCODE;
			end
		endcase
	end

	// state, counters and branch flag
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= ST_OPCODE;
			cnt_reg <= 4'h0;
			total_reg <= 4'h0;
			taken_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			total_reg <= total_next;
			taken_reg <= taken_next;
		end
	end

	// byte counter and latched decode of the current instruction
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			bytes_reg <= 2'h0;
			infoReg <= '0;
			opcodeOut <= 8'h00;
		end else if (accept) begin
			bytes_reg <= BYTES_ONE;
			infoReg <= info;
			opcodeOut <= codeByte;
		end else if (operandTake) begin
			bytes_reg <= bytes_reg + BYTES_ONE;
		end
	end

	// operand bytes in program order; the offset is always the last one
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			operand1 <= 8'h00;
			operand2 <= 8'h00;
		end else if (operandTake) begin
			if (bytes_reg == BYTES_ONE) begin
				operand1 <= codeByte;
			end else begin
				operand2 <= codeByte;
			end
		end
	end

	// ----------------------------------------------------------------
	// program counter
	// ----------------------------------------------------------------
	logic [7:0] relByte;
	logic [15:0] branchTarget;

	assign relByte = (infoReg.len == 2'h3) ? operand2 : operand1;
	// fetchAddr already points past the last byte once the offset is in
	// (RQ19) signed offset from the next instruction
	assign branchTarget = fetchAddr + sext(relByte);

	// branch redirect wins over a pipeline load in the same cycle
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			fetchAddr <= PC_RESET;
		end else if (accept || operandTake) begin
			fetchAddr <= fetchAddr + 16'h0001;
		end else if ((state_reg == ST_EXEC) && lastCycle && taken_reg) begin
			fetchAddr <= branchTarget;
		end else if (pcLoad) begin
			fetchAddr <= pcLoadValue;
		end
	end

	// ----------------------------------------------------------------
	// completion and memory strobes
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			instrDone <= 1'b0;
			busy <= 1'b0;
		end else begin
			instrDone <= lastCycle;
			busy <= (state_next != ST_OPCODE);
		end
	end

	// external writes steer to flash only while program store is enabled
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			extWriteStrobe <= 1'b0;
			flashTarget <= 1'b0;
			extAddr <= 16'h0000;
		end else begin
			// (RQ5) write lands in RAM or flash
			extWriteStrobe <= lastCycle && infoReg.extWrite && (state_reg == ST_EXEC);
			if (lastCycle && infoReg.extWrite && (state_reg == ST_EXEC)) begin
				flashTarget <= programStoreEnable;
				extAddr <= (opcodeOut == OP_XWRITE_DP) ? dataPointer : {8'h00, pointerReg};
			end
		end
	end

	// code reads from the PC (83) use the next instruction address as base, 93 uses dataPointer
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			codeReadStrobe <= 1'b0;
			codeReadAddr <= 16'h0000;
		end else begin
			// (RQ14) code byte read at accumulator plus base
			codeReadStrobe <= lastCycle && infoReg.codeRead && (state_reg == ST_EXEC);
			if (lastCycle && infoReg.codeRead && (state_reg == ST_EXEC)) begin
				codeReadAddr <= {8'h00, accValue} +
					((opcodeOut == OP_CODE_READ_DP) ? dataPointer : fetchAddr);
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	a_max_occupancy: assert property (cnt_reg <= MAX_CLOCKS) // (RQ18)
		else $error("instruction held the pipeline past eight clocks");

	a_bank_add_one: assert property (accept && codeByte[7:3] == 5'h05 |=> instrDone) // (RQ6)
		else $error("bank register add did not finish in one clock");

	a_indirect_two: assert property (accept && codeByte == 8'h26 // (RQ7)
		|=> !instrDone ##1 instrDone)
		else $error("indirect add did not take two clocks");

	a_direct_add_two: assert property (accept && codeByte == 8'h25 ##1 codeValid // (RQ8)
		|=> instrDone)
		else $error("direct add did not take two clocks");

	a_logic_imm_three: assert property (accept && codeByte == 8'h53 // (RQ9)
		##1 codeValid[*2] |=> instrDone)
		else $error("immediate into direct not three clocks");

	a_swap_one: assert property (accept && codeByte == 8'hC4 |=> instrDone && !busy) // (RQ10)
		else $error("nibble swap did not finish in one clock");

	a_pointer_load_three: assert property (accept && codeByte == 8'h90 // (RQ13)
		##1 codeValid[*2] |=> instrDone)
		else $error("data pointer load not three clocks");

	a_ext_write_three: assert property (accept && codeByte == 8'hF0 // (RQ15)
		|=> !instrDone[*2] ##1 (instrDone && extWriteStrobe))
		else $error("external write not three clocks");

	a_flash_target: assert property (extWriteStrobe // (RQ5)
		|-> flashTarget == $past(programStoreEnable))
		else $error("external write target not taken from store enable");

	a_low_nibble_two: assert property (accept && codeByte == 8'hD6 // (RQ17)
		|=> !instrDone ##1 instrDone)
		else $error("low nibble exchange did not take two clocks");

	a_jc_untaken: assert property (accept && codeByte == 8'h40 // (RQ4)
		##1 (codeValid && !branchCond) |=> instrDone)
		else $error("untaken branch did not finish in two clocks");

	a_jc_taken: assert property (accept && codeByte == 8'h40 // (RQ19)
		##1 (codeValid && branchCond)
		|=> !instrDone ##1 (instrDone && fetchAddr == $past(branchTarget)))
		else $error("taken branch timing or target wrong");

	a_short_jump: assert property (accept && codeByte == 8'h80 ##1 codeValid // (RQ19)
		|=> !instrDone ##1 (instrDone && fetchAddr == $past(branchTarget)))
		else $error("short jump timing or target wrong");

	a_compare_taken: assert property (accept && codeByte == 8'hB4 // (RQ4)
		##1 codeValid ##1 (codeValid && branchCond)
		|=> !instrDone ##1 (instrDone && fetchAddr == $past(branchTarget)))
		else $error("taken three byte branch timing or target wrong");

	a_compare_untaken: assert property (accept && codeByte == 8'hB4 // (RQ4)
		##1 codeValid ##1 (codeValid && !branchCond) |=> instrDone)
		else $error("untaken three byte branch not three clocks");

	a_code_read_three: assert property (accept && codeByte == 8'h93 // (RQ14)
		|=> !codeReadStrobe[*2] ##1 (codeReadStrobe && instrDone))
		else $error("code byte read not three clocks");

	a_ext_read_quiet: assert property (accept && codeByte == 8'hE0 // (RQ15)
		|=> !extWriteStrobe[*2] ##1 (instrDone && !extWriteStrobe))
		else $error("external read not three clocks or raised a write");

	a_write_addr_wide: assert property (extWriteStrobe && opcodeOut == OP_XWRITE_DP // (RQ15)
		|-> extAddr == $past(dataPointer))
		else $error("wide external write address not from data pointer");

	a_multiply_four: assert property (accept && codeByte == 8'hA4 // (RQ2)
		|=> !instrDone[*3] ##1 instrDone)
		else $error("multiply did not take four clocks");

	a_divide_eight: assert property (accept && codeByte == 8'h84 // (RQ18)
		|=> !instrDone[*7] ##1 instrDone)
		else $error("divide did not take eight clocks");

	a_push_two: assert property (accept && codeByte == 8'hC0 ##1 codeValid // (RQ16)
		|=> instrDone)
		else $error("push did not take two clocks");

	a_store_ind_two: assert property (accept && codeByte == 8'h76 ##1 codeValid // (RQ12)
		|=> instrDone)
		else $error("store into indirect did not take two clocks");

	a_xor_direct_two: assert property (accept && codeByte == 8'h62 ##1 codeValid // (RQ20)
		|=> instrDone)
		else $error("xor into direct did not take two clocks");

	a_move_dd_three: assert property (accept && codeByte == 8'h85 // (RQ11)
		##1 codeValid[*2] |=> instrDone)
		else $error("direct to direct move not three clocks");

	c_taken_branch: cover property (taken_reg && instrDone);
	c_ext_write: cover property (extWriteStrobe && flashTarget);
	c_code_read: cover property (codeReadStrobe);
	c_long_divide: cover property (cnt_reg == MAX_CLOCKS);
	c_three_byte_branch: cover property (taken_reg && instrDone && infoReg.len == 2'h3);

endmodule

//--- prog_mem_model.sv
// behavioural program memory that feeds the fetch port of the sequencer
module prog_mem_model (
	// clock
	input wire logic clk,
	// fetch side
	input wire logic [15:0] fetchAddr,
	output logic [7:0] codeByte,
	output logic codeValid,
	// bench control: slow answers and program loading
	input wire logic stall,
	input wire logic memWe,
	input wire logic [15:0] memAddr,
	input wire logic [7:0] memData
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [7:0] mem [0:65535];
	logic [7:0] lastByte_reg;

	// start as all no-operation so a stray fetch stays harmless
	initial begin
		for (int i = 0; i < 65536; i++) begin
			mem[i] = 8'h00;
		end
	end

	// loading port, written on the rising edge; plain always as the fill also writes it
	always @(posedge clk) begin
		if (memWe) begin
			mem[memAddr] <= memData;
		end
	end

	// remember the byte on the lines so a withheld byte can be garbled
	always_ff @(posedge clk) begin
		lastByte_reg <= codeByte;
	end

	// while stalled the lines carry the inverted last byte, back to the stale byte every second stalled cycle
	assign codeByte = stall ? ~lastByte_reg : mem[fetchAddr];
	assign codeValid = ~stall;
endmodule

//--- tb_pipelined_mcu_instruction_timing.sv
// self-checking bench for the instruction timing sequencer
module tb_pipelined_mcu_instruction_timing;
	import instr_timing_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;

	localparam logic [15:0] BASE = 16'h0100;

	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] codeByte;
	logic codeValid;
	logic [15:0] fetchAddr;
	logic branchCond = 1'b0;
	logic pcLoad = 1'b0;
	logic [15:0] pcLoadValue = 16'h0000;
	logic [7:0] accValue = 8'h10;
	logic [15:0] dataPointer = 16'h1234;
	logic [7:0] pointerReg = 8'h56;
	logic programStoreEnable = 1'b1;
	logic [7:0] opcodeOut, operand1, operand2;
	logic instrDone, busy, extWriteStrobe, flashTarget, codeReadStrobe;
	logic [15:0] extAddr, codeReadAddr;
	logic stall = 1'b1;
	logic memWe = 1'b0;
	logic [15:0] memAddr = 16'h0000;
	logic [7:0] memData = 8'h00;
	int err_total = 0;
	int num_checks = 0;

	always #(CLK_PERIOD_NS / 2.0) clk = ~clk;

	instr_timing u_dut (.clk(clk), .resetn(resetn), .codeByte(codeByte), .codeValid(codeValid),
		.fetchAddr(fetchAddr), .branchCond(branchCond), .pcLoad(pcLoad),
		.pcLoadValue(pcLoadValue), .accValue(accValue), .dataPointer(dataPointer),
		.pointerReg(pointerReg), .programStoreEnable(programStoreEnable),
		.opcodeOut(opcodeOut), .operand1(operand1), .operand2(operand2),
		.instrDone(instrDone), .busy(busy), .extWriteStrobe(extWriteStrobe),
		.flashTarget(flashTarget), .extAddr(extAddr), .codeReadStrobe(codeReadStrobe),
		.codeReadAddr(codeReadAddr));

	prog_mem_model u_mem (.clk(clk), .fetchAddr(fetchAddr), .codeByte(codeByte),
		.codeValid(codeValid), .stall(stall), .memWe(memWe), .memAddr(memAddr),
		.memData(memData));

	// ----------------------------------------------------------------
	// shared helpers
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// reset, load the program at BASE, jump there while fetch is held off
	task automatic start(input logic [7:0] p[$]);
		@(negedge clk);
		stall = 1'b1;
		resetn = 1'b0;
		foreach (p[k]) begin
			@(negedge clk);
			memWe = 1'b1;
			memAddr = BASE + 16'(k);
			memData = p[k];
		end
		@(negedge clk);
		memWe = 1'b0;
		resetn = 1'b1;
		@(negedge clk);
		pcLoad = 1'b1;
		pcLoadValue = BASE;
		@(negedge clk);
		pcLoad = 1'b0;
		stall = 1'b0;
	endtask

	// count clocks up to the done pulse of one instruction, bounded
	task automatic step(input logic [7:0] op, input int clkE, input logic [15:0] nextE);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (instrDone !== 1'b1 && n < 12);
		check("clock count", 16'(n), 16'(clkE));
		check("opcode", {8'h00, opcodeOut}, {8'h00, op});
		check("next address", fetchAddr, nextE);
	endtask

	// back-to-back run of opcodes sharing one byte count and clock cost
	task automatic run_group(input string name, input logic [7:0] ops[$], input int lenE,
		input int clkE);
		logic [7:0] p[$];
		logic [15:0] a;
		foreach (ops[i]) begin
			p.push_back(ops[i]);
			repeat (lenE - 1) p.push_back(8'h5A);
		end
		start(p);
		a = BASE;
		foreach (ops[i]) begin
			a = a + 16'(lenE);
			step(ops[i], clkE, a);
		end
		stall = 1'b1;
		$display("test %s done", name);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_groups;
		run_group("one clock", {8'h28, 8'h38, 8'h98, 8'h04, 8'h08, 8'h14, 8'h18, 8'h58,
			8'h48, 8'h68, 8'hE8, 8'hF8, 8'hC8, 8'hA3, 8'hD4, 8'hE4, 8'hF4, 8'h23, 8'h33,
			8'h03, 8'h13, 8'hC4}, 1, 1);
		run_group("indirect", {8'h26, 8'h36, 8'h96, 8'h06, 8'h16, 8'h56, 8'h46, 8'h66,
			8'hE6, 8'hF6, 8'hC6, 8'hD6}, 1, 2);
		run_group("two byte", {8'h25, 8'h24, 8'h35, 8'h34, 8'h95, 8'h94, 8'h55, 8'h54,
			8'h45, 8'h44, 8'h65, 8'h64, 8'hE5, 8'h74, 8'h62, 8'hC0, 8'hD0, 8'hA6, 8'h76,
			8'h05, 8'h15, 8'h52, 8'h42}, 2, 2);
		run_group("three byte", {8'h53, 8'h43, 8'h63, 8'h85, 8'h75, 8'h90}, 3, 3);
		run_group("multiply", {8'hA4}, 1, 4);
		run_group("divide", {8'h84}, 1, 8);
	endtask

	// writes go to flash or RAM, code reads form their address
	task automatic t_external;
		programStoreEnable = 1'b1;
		start({8'hF0, 8'hF2, 8'hE0, 8'hE2, 8'h93, 8'h83});
		step(8'hF0, 3, BASE + 16'h0001);
		check("write strobe", 16'(extWriteStrobe), 16'h0001);
		check("flash target", 16'(flashTarget), 16'h0001);
		check("write address", extAddr, 16'h1234);
		programStoreEnable = 1'b0;
		step(8'hF2, 3, BASE + 16'h0002);
		check("ram target", 16'(flashTarget), 16'h0000);
		check("short address", extAddr, 16'h0056);
		step(8'hE0, 3, BASE + 16'h0003);
		check("no write on read", 16'(extWriteStrobe), 16'h0000);
		step(8'hE2, 3, BASE + 16'h0004);
		step(8'h93, 3, BASE + 16'h0005);
		check("code read strobe", 16'(codeReadStrobe), 16'h0001);
		check("pointer code address", codeReadAddr, 16'h1244);
		step(8'h83, 3, BASE + 16'h0006);
		check("pc code address", codeReadAddr, BASE + 16'h0016);
		stall = 1'b1;
		$display("test external done");
	endtask

	// each conditional jump taken and not taken; 40 and 60 forward, 50 and 70 backward
	task automatic t_branch;
		logic [7:0] ops [4];
		logic [7:0] rel;
		logic [15:0] tgt;
		ops = '{8'h40, 8'h50, 8'h60, 8'h70};
		for (int i = 0; i < 8; i++) begin
			rel = i[1] ? 8'hFC : 8'h02;
			branchCond = i[0];
			start({ops[i / 2], rel});
			tgt = BASE + 16'h0002 + {{8{rel[7]}}, rel};
			if (i[0]) begin
				step(ops[i / 2], 3, tgt);
			end else begin
				step(ops[i / 2], 2, BASE + 16'h0002);
			end
			stall = 1'b1;
		end
		// three byte compare takes its offset from the last byte
		for (int i = 0; i < 2; i++) begin
			branchCond = i[0];
			start({8'hB4, 8'h5A, 8'hFC});
			step(8'hB4, 3 + i, i[0] ? BASE - 16'h0001 : BASE + 16'h0003);
			stall = 1'b1;
		end
		// the short jump is taken whatever the condition input says
		branchCond = 1'b0;
		start({8'h80, 8'h02});
		step(8'h80, 3, BASE + 16'h0004);
		stall = 1'b1;
		$display("test branch done");
	endtask

	// a withheld operand byte delays the end and is not taken as data
	task automatic t_stall;
		start({8'h75, 8'h5A, 8'hA5});
		@(negedge clk);
		stall = 1'b1;
		check("busy after opcode", 16'(busy), 16'h0001);
		@(negedge clk);
		check("done during stall", 16'(instrDone), 16'h0000);
		check("busy during stall", 16'(busy), 16'h0001);
		stall = 1'b0;
		repeat (2) @(negedge clk);
		check("done after stall", 16'(instrDone), 16'h0001);
		check("busy at end", 16'(busy), 16'h0000);
		check("operand byte", {8'h00, operand1}, 16'h005A);
		check("second operand", {8'h00, operand2}, 16'h00A5);
		check("address after stall", fetchAddr, BASE + 16'h0003);
		stall = 1'b1;
		$display("test stall done");
	endtask

	// ----------------------------------------------------------------
	// verdict, main sequence and watchdog
	// ----------------------------------------------------------------
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		repeat (2) @(posedge clk);
		@(negedge clk);
		resetn = 1'b1;
		t_groups();
		t_external();
		t_branch();
		t_stall();
		print_verdict();
	end

	// whole run needs a few hundred clocks; a hang ends here
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		print_verdict();
	end
endmodule
